// ### rtl/tfse_engine.sv
`timescale 1ns/1ps
module tfse_engine
  import tfse_pkg::*;
#(
  parameter logic [16:0] ADDR_LIMIT = ADDR_LIMIT_DEF
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Operation request
  input wire logic start_i,
  input wire logic [1:0] op_i,
  input wire logic [1:0] src_i,
  input wire logic [15:0] operand_i,
  // Accumulator and operand stack
  input wire logic [31:0] acc_i,
  input wire logic [31:0] stack1_i,
  input wire logic [31:0] stack2_i,
  // Word memory
  output logic [15:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [15:0] mem_wdata_o,
  input wire logic [15:0] mem_rdata_i,
  // Results
  output logic busy_o,
  output logic done_o,
  output logic [31:0] acc_o,
  output logic acc_we_o,
  output logic range_error_flag_o,
  output logic flag_we_o
);

  tfse_state_t state_q, state_d;
  logic [1:0] op_q, op_d;
  logic [15:0] len_q, len_d;
  logic [15:0] base_q, base_d;
  logic [15:0] idx_q, idx_d;
  logic [15:0] key_q, key_d;
  logic v1_q, v1_d;
  logic v2_q, v2_d;
  logic [15:0] rdx1_q, rdx1_d;
  logic [15:0] rdx2_q, rdx2_d;
  logic [15:0] mem_addr_q, mem_addr_d;
  logic mem_rd_q, mem_rd_d;
  logic mem_wr_q, mem_wr_d;
  logic [15:0] mem_wdata_q, mem_wdata_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic [31:0] acc_q, acc_d;
  logic acc_we_q, acc_we_d;
  logic flag_q, flag_d;
  logic flag_we_q, flag_we_d;

  // Request decode, taken straight from the inputs in idle
  logic [15:0] req_len;
  logic [15:0] req_base;
  logic [15:0] req_start;
  logic [16:0] req_end;
  logic req_bad;

  always_comb begin
    req_len = stack1_i[15:0];
    req_base = acc_i[15:0];
    req_start = WORD_ZERO;
    case (op_i)
      OP_FIND: begin
        req_len = stack2_i[15:0];
        req_base = stack1_i[15:0];
        req_start = acc_i[15:0];
      end
      OP_GREATER: begin
        req_len = stack1_i[15:0];
        req_base = acc_i[15:0];
        req_start = WORD_ZERO;
      end
      default: begin
        req_len = stack1_i[15:0];
        req_base = acc_i[15:0];
        req_start = WORD_ZERO;
      end
    endcase
    req_end = {1'b0, req_base} + {1'b0, req_len};
    // Whole table checked up front so no partial fill lands
    req_bad = (req_len > MAX_TABLE_LEN)
      || (req_end > ADDR_LIMIT);
    if (op_i == OP_FIND && req_start >= req_len) begin
      req_bad = 1'b1;
    end
  end

  // Sequencer
  logic fin;
  logic fail;
  logic [15:0] res;
  logic hit;

  always_comb begin
    state_d = state_q;
    op_d = op_q;
    len_d = len_q;
    base_d = base_q;
    idx_d = idx_q;
    key_d = key_q;
    v1_d = 1'b0;
    v2_d = v1_q;
    rdx1_d = rdx1_q;
    rdx2_d = rdx1_q;
    mem_addr_d = mem_addr_q;
    mem_rd_d = 1'b0;
    mem_wr_d = 1'b0;
    mem_wdata_d = mem_wdata_q;
    done_d = 1'b0;
    acc_d = acc_q;
    acc_we_d = 1'b0;
    flag_d = flag_q;
    flag_we_d = 1'b0;
    fin = 1'b0;
    fail = 1'b0;
    res = WORD_ZERO;
    hit = 1'b0;
    if (op_q == OP_GREATER) begin
      hit = mem_rdata_i > key_q;
    end else begin
      hit = mem_rdata_i == key_q;
    end
    case (state_q)
      TFSE_IDLE: begin
        if (start_i) begin
          op_d = op_i;
          len_d = req_len;
          base_d = req_base;
          idx_d = req_start;
          key_d = operand_i;
          if (req_bad) begin
            fin = 1'b1;
            fail = 1'b1;
          end else if (src_i == SRC_IMM) begin
            state_d = TFSE_RUN;
          end else begin
            mem_addr_d = operand_i;
            mem_rd_d = 1'b1;
            v1_d = 1'b1;
            if (src_i == SRC_PTR) begin
              state_d = TFSE_PTR;
            end else begin
              state_d = TFSE_KEY;
            end
          end
        end
      end
      TFSE_PTR: begin
        // Pointer word names the operand word
        if (v2_q) begin
          mem_addr_d = mem_rdata_i;
          mem_rd_d = 1'b1;
          v1_d = 1'b1;
          state_d = TFSE_KEY;
        end
      end
      TFSE_KEY: begin
        if (v2_q) begin
          key_d = mem_rdata_i;
          state_d = TFSE_RUN;
        end
      end
      TFSE_RUN: begin
        if (op_q == OP_FILL) begin
          if (idx_q < len_q) begin
            mem_addr_d = base_q + idx_q;
            mem_wdata_d = key_q;
            mem_wr_d = 1'b1;
            idx_d = idx_q + 16'h0001;
          end else begin
            fin = 1'b1;
          end
        end else if (v2_q && hit) begin
          // Reads still in flight are dropped on a hit
          fin = 1'b1;
          res = rdx2_q;
        end else if (idx_q < len_q) begin
          mem_addr_d = base_q + idx_q;
          mem_rd_d = 1'b1;
          v1_d = 1'b1;
          rdx1_d = idx_q;
          idx_d = idx_q + 16'h0001;
        end else if (!v1_q && !v2_q) begin
          fin = 1'b1;
          fail = 1'b1;
          res = WORD_ZERO;
        end
      end
      TFSE_DONE: begin
        state_d = TFSE_IDLE;
      end
      default: begin
        state_d = TFSE_IDLE;
      end
    endcase
    if (fin) begin
      state_d = TFSE_DONE;
      done_d = 1'b1;
      flag_d = fail;
      flag_we_d = 1'b1;
      if (op_d != OP_FILL) begin
        acc_d = {16'h0000, res};
        acc_we_d = 1'b1;
      end
    end
    busy_d = state_d != TFSE_IDLE;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= TFSE_IDLE;
      op_q <= OP_FILL;
      len_q <= WORD_ZERO;
      base_q <= WORD_ZERO;
      idx_q <= WORD_ZERO;
      key_q <= WORD_ZERO;
      v1_q <= 1'b0;
      v2_q <= 1'b0;
      rdx1_q <= WORD_ZERO;
      rdx2_q <= WORD_ZERO;
      mem_addr_q <= WORD_ZERO;
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mem_wdata_q <= WORD_ZERO;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      acc_q <= ACC_ZERO;
      acc_we_q <= 1'b0;
      flag_q <= 1'b0;
      flag_we_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      len_q <= len_d;
      base_q <= base_d;
      idx_q <= idx_d;
      key_q <= key_d;
      v1_q <= v1_d;
      v2_q <= v2_d;
      rdx1_q <= rdx1_d;
      rdx2_q <= rdx2_d;
      mem_addr_q <= mem_addr_d;
      mem_rd_q <= mem_rd_d;
      mem_wr_q <= mem_wr_d;
      mem_wdata_q <= mem_wdata_d;
      busy_q <= busy_d;
      done_q <= done_d;
      acc_q <= acc_d;
      acc_we_q <= acc_we_d;
      flag_q <= flag_d;
      flag_we_q <= flag_we_d;
    end
  end

  // Every output straight from a flip-flop
  assign mem_addr_o = mem_addr_q;
  assign mem_rd_o = mem_rd_q;
  assign mem_wr_o = mem_wr_q;
  assign mem_wdata_o = mem_wdata_q;
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign acc_o = acc_q;
  assign acc_we_o = acc_we_q;
  assign range_error_flag_o = flag_q;
  assign flag_we_o = flag_we_q;

endmodule

// ### include/tfse_pkg.sv
package tfse_pkg;
  // Operation select
  localparam logic [1:0] OP_FILL = 2'h0;
  localparam logic [1:0] OP_FIND = 2'h1;
  localparam logic [1:0] OP_GREATER = 2'h2;
  // Operand source select
  localparam logic [1:0] SRC_MEM = 2'h0;
  localparam logic [1:0] SRC_PTR = 2'h1;
  localparam logic [1:0] SRC_IMM = 2'h2;
  // Table limits
  localparam logic [15:0] MAX_TABLE_LEN = 16'h00FF;
  localparam logic [16:0] ADDR_LIMIT_DEF = 17'h0_4000;
  // Reset values
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [31:0] ACC_ZERO = 32'h0000_0000;
  typedef enum logic [2:0] {
    TFSE_IDLE,
    TFSE_PTR,
    TFSE_KEY,
    TFSE_RUN,
    TFSE_DONE
  } tfse_state_t;
endpackage

// ### verif/tfse_checker.sv
`timescale 1ns/1ps
module tfse_checker
  import tfse_pkg::*;
#(
  parameter logic [16:0] ADDR_LIMIT = ADDR_LIMIT_DEF
) (
  // Engine ports, watched only
  input wire logic sys_clk_i, rst_i, start_i, mem_wr_o, busy_o, done_o,
  input wire logic acc_we_o, range_error_flag_o, flag_we_o,
  input wire logic [1:0] op_i,
  input wire logic [15:0] mem_addr_o, mem_wdata_o,
  input wire logic [31:0] acc_o
);
  logic [1:0] op_q;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) op_q <= 2'h0;
    else if (start_i && !busy_o) op_q <= op_i;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_start_busy: assert property (start_i && !busy_o |=> busy_o)
    else $error("busy missing");
  a_done_pulse: assert property (
    done_o |-> busy_o ##1 (!done_o && !busy_o)) else $error("done long");
  a_flag_done: assert property (flag_we_o == done_o)
    else $error("flag write");
  a_acc_search: assert property (
    acc_we_o == (done_o && op_q != OP_FILL)) else $error("acc write");
  a_miss_zero: assert property (
    acc_we_o && range_error_flag_o |-> acc_o == ACC_ZERO) else $error("miss");
  a_flag_hold: assert property (
    !flag_we_o |-> $stable(range_error_flag_o)) else $error("flag moved");
  a_fill_write: assert property (
    mem_wr_o |-> op_q == OP_FILL && {1'b0, mem_addr_o} < ADDR_LIMIT)
    else $error("bad write");
  a_fill_step: assert property (
    mem_wr_o && $past(mem_wr_o) |-> $stable(mem_wdata_o) &&
    mem_addr_o == $past(mem_addr_o) + 16'h0001) else $error("write step");
  c_fill: cover property (mem_wr_o ##1 !mem_wr_o);
  c_hit: cover property (acc_we_o && !range_error_flag_o);
  c_miss: cover property (acc_we_o && range_error_flag_o);
endmodule

bind tfse_engine tfse_checker #(.ADDR_LIMIT(ADDR_LIMIT)) chk_u (.*);

// ### verif/tfse_mem_model.sv
`timescale 1ns/1ps
// Word memory with one cycle read latency
module tfse_mem_model (
  input wire logic sys_clk_i, rd_i, wr_i,
  input wire logic [15:0] a_i, d_i,
  output logic [15:0] q_o
);
  logic [15:0] m [512];
  initial q_o = 16'h0000;
  always @(posedge sys_clk_i) begin
    if (wr_i) m[a_i[8:0]] <= d_i;
    // Idle cycles invert, so stale data never looks valid
    q_o <= rd_i ? m[a_i[8:0]] : ~q_o;
  end
endmodule

// ### verif/test_table_fill_search_engine.sv
`timescale 1ns/1ps
module test_table_fill_search_engine;
  import tfse_pkg::*;
  localparam logic [16:0] LIM = 17'h0_0200;
  logic sys_clk_i = '0, rst_i = 1'b1, start_i = '0, mem_rd_o, mem_wr_o;
  logic busy_o, done_o, acc_we_o, range_error_flag_o, flag_we_o;
  logic [1:0] op_i = '0, src_i = '0;
  logic [15:0] operand_i = '0, mem_addr_o, mem_wdata_o, mem_rdata_i, k, hi;
  logic [31:0] acc_i = '0, stack1_i = '0, stack2_i = '0, acc_o;
  logic [16:0] e;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  always #20 sys_clk_i = ~sys_clk_i;
  tfse_engine #(.ADDR_LIMIT(LIM)) dut (.*);
  tfse_mem_model mu (.sys_clk_i, .a_i(mem_addr_o), .rd_i(mem_rd_o),
    .wr_i(mem_wr_o), .d_i(mem_wdata_o), .q_o(mem_rdata_i));
  task automatic chk(string s, logic [31:0] x, g);
    cmp_count++;
    if (g !== x) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk_i)
    if (++cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  // Expected {flag, offset}; a miss gives offset zero
  function automatic logic [16:0] ex(logic [1:0] op, logic [15:0] b, n, o);
    if (n > 16'h00ff || {1'b0, b} + n > LIM || (op == OP_FIND && o >= n))
      return 17'h1_0000;
    if (op == OP_FILL) return '0;
    for (int i = op == OP_FIND ? o : 0; i < n; i++)
      if (op == OP_FIND ? mu.m[b + i] == k : mu.m[b + i] > k)
        return 17'(i);
    return 17'h1_0000;
  endfunction
  task automatic go(logic [1:0] op, s, logic [15:0] d, b, n, o);
    k = s == SRC_IMM ? d :
      mu.m[s == SRC_PTR ? mu.m[d[8:0]][8:0] : d[8:0]];
    e = ex(op, b, n, o);
    hi = mu.m[9'(b + n)];
    @(posedge sys_clk_i);
    {start_i, op_i, src_i, operand_i} <= {1'b1, op, s, d};
    acc_i <= {16'($urandom), op == OP_FIND ? o : b};
    stack1_i <= {16'($urandom), op == OP_FIND ? b : n};
    stack2_i <= {16'($urandom), n};
    // Start held a second cycle: must be ignored while busy
    repeat (2) @(posedge sys_clk_i);
    start_i <= 1'b0;
    for (int t = 0; t < 600 && done_o !== 1'b1; t++) @(posedge sys_clk_i);
    chk("flag", e[16], range_error_flag_o);
    if (op != OP_FILL) chk("acc", e[15:0], acc_o);
    for (int i = 0; i < n && op == OP_FILL && !e[16]; i++)
      chk("word", k, mu.m[b + i]);
    if (op == OP_FILL) chk("next", hi, mu.m[9'(b + n)]);
    $display("test op %0d len %0d done", op, n);
  endtask
  initial begin
    void'($urandom(32'hf44c_8328));
    for (int i = 0; i < 512; i++) mu.m[i] = 16'($urandom % 8);
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    go(OP_FILL, SRC_IMM, 16'h5a5a, 16'h0010, '0, '0);
    go(OP_FILL, SRC_MEM, 16'h0101, 16'h0100, 16'h00ff, '0);
    go(OP_FILL, SRC_PTR, 16'h0104, 16'h01f4, 16'h000d, '0);
    go(OP_FILL, SRC_IMM, 16'h1234, 16'h0000, 16'h0100, '0);
    {mu.m[101], mu.m[102], mu.m[103], mu.m[104]} = 64'h0007_0000_0000_0007;
    go(OP_FIND, SRC_IMM, 16'h0007, 16'h0064, 16'h0006, 16'h0002);
    go(OP_FIND, SRC_IMM, 16'h0007, 16'h0064, 16'h0006, 16'h0006);
    go(OP_GREATER, SRC_IMM, 16'hffff, 16'h0064, 16'h00ff, '0);
    repeat (40)
      go(2'($urandom % 3), 2'($urandom % 3), 16'($urandom % 10),
        16'($urandom % 490), 16'($urandom % 40), 16'($urandom % 12));
    print_verdict();
  end
endmodule
